// ### src/nvp_pkg.sv
package nvp_pkg;
  // ==========================================================
  // register map (I/O space offsets)
  localparam logic [5:0] NVP_IO_CONTROL = 6'h1C;
  localparam logic [5:0] NVP_IO_DATA = 6'h1D;
  localparam logic [5:0] NVP_IO_ADDR_LOW = 6'h1E;
  localparam logic [5:0] NVP_IO_ADDR_HIGH = 6'h1F;
  localparam int NVP_IO_AW = 6;
  // ==========================================================
  // control register fields, data register reset value and erased byte value
  localparam int NVP_BIT_READ_STROBE = 0;
  localparam int NVP_BIT_PROGRAM_ENABLE = 1;
  localparam int NVP_BIT_MASTER_ENABLE = 2;
  localparam int NVP_BIT_READY_IE = 3;
  localparam int NVP_BIT_MODE_LO = 4;
  localparam int NVP_BIT_MODE_HI = 5;
  localparam logic [7:0] NVP_DATA_RESET = 8'h00;
  localparam logic [7:0] NVP_ERASED = 8'hFF;
  // ==========================================================
  // geometry
  localparam int NVP_ADDR_W = 9;
  localparam int NVP_DEPTH = 512;
  // ==========================================================
  // programming modes
  typedef enum logic [1:0]
  {
    NVP_MODE_ATOMIC = 2'h0,
    NVP_MODE_ERASE = 2'h1,
    NVP_MODE_WRITE = 2'h2,
    NVP_MODE_RSVD = 2'h3
  } nvp_mode_t;
  // ==========================================================
  // timing
  localparam int NVP_CLK_MHZ = 125;
  localparam int NVP_ATOMIC_US = 3400;
  localparam int NVP_SPLIT_US = 1800;
  localparam int NVP_ATOMIC_CYC = NVP_ATOMIC_US * NVP_CLK_MHZ;
  localparam int NVP_SPLIT_CYC = NVP_SPLIT_US * NVP_CLK_MHZ;
  localparam logic [2:0] NVP_MASTER_WINDOW = 3'h4;
  localparam logic [2:0] NVP_READ_STALL = 3'h4;
  localparam logic [2:0] NVP_WRITE_STALL = 3'h2;
  localparam int NVP_TIMER_W = 20;
endpackage

// ### src/nvp_store.sv
`timescale 1ns/1ns
// byte store with one shared address, asynchronous read and clocked write
module nvp_store
(
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic [nvp_pkg::NVP_ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  import nvp_pkg::*;

  logic [7:0] mem [0:NVP_DEPTH-1];

  assign rd_data = mem[addr];

  always_ff @(posedge ref_clk)
  begin
    if (clk_en && wr_en)
    begin
      mem[addr] <= wr_data;
    end
  end
endmodule

// ### src/nvp_port.sv
`timescale 1ns/1ns
// ==========================================================
// byte-wide nonvolatile store access port on the I/O bus
// Functional notes
// - registers live in processor I/O space
// - store is separate, byte addressable space
// - 9-bit address: high bit0, low byte
// - high address bits 7:1 read zero
// - bytes addressed linearly per capacity
// - address registers not reset
// - write programs data byte at address
// - read loads addressed byte into data
// - data register resets zero, read/write
// - self-timed programming with busy status
// - read stalls processor four cycles
// - write start stalls processor two cycles
// - master enable lasts four cycles
// - mode field selects action and time
// - program enable clears when time elapses
// - read strobe; refused while writing
module nvp_port
#(
  parameter int CAPACITY = 512,
  parameter int ATOMIC_CYC = nvp_pkg::NVP_ATOMIC_CYC,
  parameter int SPLIT_CYC = nvp_pkg::NVP_SPLIT_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [nvp_pkg::NVP_IO_AW-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic nv_busy
);
  import nvp_pkg::*;

  typedef enum logic [1:0]
  {
    NVP_ST_IDLE = 2'b01,
    NVP_ST_PROG = 2'b10
  } nvp_state_t;

  // ========================================================
  // helpers
  function automatic logic [NVP_ADDR_W-1:0] nvp_clip
  (
    input logic [NVP_ADDR_W-1:0] a
  );
    nvp_clip = a & NVP_ADDR_W'(CAPACITY - 1);
  endfunction

  function automatic logic [NVP_TIMER_W-1:0] nvp_time
  (
    input logic [1:0] m
  );
    if (m == NVP_MODE_ATOMIC)
    begin
      nvp_time = NVP_TIMER_W'(ATOMIC_CYC - 1);
    end
    else
    begin
      nvp_time = NVP_TIMER_W'(SPLIT_CYC - 1);
    end
  endfunction

  function automatic logic nvp_hit
  (
    input logic [NVP_IO_AW-1:0] a,
    input logic [NVP_IO_AW-1:0] off
  );
    nvp_hit = (a == off);
  endfunction

  // ========================================================
  // state
  nvp_state_t state_reg, state_next;
  logic [7:0] data_reg, data_next;
  logic [NVP_ADDR_W-1:0] addr_reg, addr_next;
  logic [1:0] mode_reg, mode_next;
  logic [1:0] pmode_reg, pmode_next;
  logic ready_ie_reg, ready_ie_next;
  logic [2:0] master_cnt_reg, master_cnt_next;
  logic [2:0] stall_cnt_reg, stall_cnt_next;
  logic [NVP_TIMER_W-1:0] timer_reg, timer_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] store_rd;
  logic store_wr;
  logic [7:0] store_wdata;

  // ========================================================
  // decode
  logic wr_ctl, wr_data, wr_alo, wr_ahi;
  logic prog, master_on;
  logic start_go, read_go;

  assign wr_ctl = io_wr && nvp_hit(io_addr, NVP_IO_CONTROL);
  assign wr_data = io_wr && nvp_hit(io_addr, NVP_IO_DATA);
  assign wr_alo = io_wr && nvp_hit(io_addr, NVP_IO_ADDR_LOW);
  assign wr_ahi = io_wr && nvp_hit(io_addr, NVP_IO_ADDR_HIGH);
  assign prog = (state_reg == NVP_ST_PROG);
  assign master_on = (master_cnt_reg != 3'h0);

  // ========================================================
  // next state
  always_comb
  begin
    state_next = state_reg;
    data_next = data_reg;
    addr_next = addr_reg;
    mode_next = mode_reg;
    pmode_next = pmode_reg;
    ready_ie_next = ready_ie_reg;
    master_cnt_next = master_cnt_reg;
    start_go = 1'b0;
    read_go = 1'b0;
    timer_next = timer_reg;
    store_wr = 1'b0;
    store_wdata = data_reg;
    if (master_on)
    begin
      master_cnt_next = master_cnt_reg - 3'h1;
    end
    if (wr_data)
    begin
      data_next = io_wdata;
    end
    if (!prog)
    begin
      if (wr_alo)
      begin
        addr_next[7:0] = io_wdata;
      end
      if (wr_ahi)
      begin
        addr_next[8] = io_wdata[0];
      end
    end
    if (wr_ctl)
    begin
      ready_ie_next = io_wdata[NVP_BIT_READY_IE];
      if (!prog)
      begin
        mode_next = io_wdata[NVP_BIT_MODE_HI:NVP_BIT_MODE_LO];
      end
      if (io_wdata[NVP_BIT_MASTER_ENABLE])
      begin
        master_cnt_next = NVP_MASTER_WINDOW;
      end
      if (io_wdata[NVP_BIT_PROGRAM_ENABLE] && master_on && !prog
          && mode_reg != NVP_MODE_RSVD)
      begin
        state_next = NVP_ST_PROG;
        pmode_next = mode_reg;
        timer_next = nvp_time(mode_reg);
        master_cnt_next = 3'h0;
        start_go = 1'b1;
      end
      else if (io_wdata[NVP_BIT_READ_STROBE] && !prog)
      begin
        data_next = store_rd;
        read_go = 1'b1;
      end
    end
    unique case (state_reg)
      NVP_ST_IDLE:
      begin
      end
      NVP_ST_PROG:
      begin
        if (timer_reg == '0)
        begin
          state_next = NVP_ST_IDLE;
          store_wr = 1'b1;
          unique case (pmode_reg)
            NVP_MODE_ERASE: store_wdata = NVP_ERASED;
            NVP_MODE_WRITE: store_wdata = store_rd & data_reg;
            default: store_wdata = data_reg;
          endcase
        end
        else
        begin
          timer_next = timer_reg - NVP_TIMER_W'(1);
        end
      end
      default:
      begin
        state_next = NVP_ST_IDLE;
      end
    endcase
  end

  // ========================================================
  // read mux
  always_comb
  begin
    rdata_next = 8'h00;
    if (io_rd)
    begin
      unique case (io_addr)
        NVP_IO_CONTROL:
        begin
          rdata_next = {2'b00, mode_reg, ready_ie_reg, master_on, prog, 1'b0};
        end
        NVP_IO_DATA: rdata_next = data_reg;
        NVP_IO_ADDR_LOW: rdata_next = addr_reg[7:0];
        NVP_IO_ADDR_HIGH: rdata_next = {7'h00, addr_reg[8]};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge ref_clk)
  begin
    if (clk_en)
    begin
      addr_reg <= addr_next;
      timer_reg <= timer_next;
      pmode_reg <= pmode_next;
      if (!rst_n)
      begin
        state_reg <= NVP_ST_IDLE;
        data_reg <= NVP_DATA_RESET;
        mode_reg <= 2'h0;
        ready_ie_reg <= 1'b0;
        master_cnt_reg <= 3'h0;
      end
      else
      begin
        state_reg <= state_next;
        data_reg <= data_next;
        mode_reg <= mode_next;
        ready_ie_reg <= ready_ie_next;
        master_cnt_reg <= master_cnt_next;
      end
    end
  end

  // ========================================================
  // processor hold counter
  always_comb
  begin
    stall_cnt_next = stall_cnt_reg;
    if (start_go)
    begin
      stall_cnt_next = NVP_WRITE_STALL;
    end
    else if (read_go)
    begin
      stall_cnt_next = NVP_READ_STALL;
    end
    else if (stall_cnt_reg != 3'h0)
    begin
      stall_cnt_next = stall_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clk_en)
    begin
      if (!rst_n)
      begin
        stall_cnt_reg <= 3'h0;
      end
      else
      begin
        stall_cnt_reg <= stall_cnt_next;
      end
    end
  end

  // ========================================================
  // read data register
  always_ff @(posedge ref_clk)
  begin
    if (clk_en)
    begin
      if (!rst_n)
      begin
        rdata_reg <= 8'h00;
      end
      else
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ========================================================
  // store
  nvp_store u_store
  (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .addr(nvp_clip(addr_reg)),
    .wr_en(store_wr),
    .wr_data(store_wdata),
    .rd_data(store_rd)
  );

  assign io_rdata = rdata_reg;
  assign cpu_stall = (stall_cnt_reg != 3'h0);
  assign nv_busy = prog;
endmodule

// ### bench/nvp_port_chk.sv
`timescale 1ns/1ns
// ==========================================================
// port checker
module nvp_port_chk
  import nvp_pkg::*;
#(
  parameter int ATOMIC_CYC = 20,
  parameter int SPLIT_CYC = 10
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [nvp_pkg::NVP_IO_AW-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_stall,
  input wire logic nv_busy
);
  logic [2:0] mcnt_reg, mcnt_next;
  logic [19:0] bcnt_reg, bcnt_next;
  logic ctl_wr;
  assign ctl_wr = io_wr && io_addr == NVP_IO_CONTROL;
  // cycles since the master enable write, and length of busy
  always_comb
  begin
    mcnt_next = mcnt_reg;
    if (ctl_wr && io_wdata[NVP_BIT_MASTER_ENABLE])
      mcnt_next = 3'h1;
    else if (mcnt_reg != 3'h0 && mcnt_reg != 3'h7)
      mcnt_next = mcnt_reg + 3'h1;
    bcnt_next = nv_busy ? bcnt_reg + 20'h1 : 20'h0;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mcnt_reg <= 3'h0;
      bcnt_reg <= 20'h0;
    end
    else if (clk_en)
    begin
      mcnt_reg <= mcnt_next;
      bcnt_reg <= bcnt_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  AST_READ_STALL: assert property (ctl_wr && io_wdata[0] &&
    !io_wdata[1] && !nv_busy |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
  AST_PROG_STALL: assert property ($rose(nv_busy) |->
    cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("program stall length wrong");
  AST_START_CAUSE: assert property ($rose(nv_busy) |->
    $past(ctl_wr) && $past(io_wdata[1]))
    else $error("busy without program enable write");
  AST_MASTER_WIN: assert property ($rose(nv_busy) |->
    $past(mcnt_reg) != 3'h0 && $past(mcnt_reg) <= 3'h4)
    else $error("program started outside master window");
  AST_BUSY_TIME: assert property ($fell(nv_busy) |->
    bcnt_reg == SPLIT_CYC || bcnt_reg == ATOMIC_CYC)
    else $error("programming time out of range");
  AST_RDATA_IDLE: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data not zero when idle");
  AST_HIGH_ZERO: assert property (io_rd &&
    io_addr == NVP_IO_ADDR_HIGH |=> io_rdata[7:1] == 7'h00)
    else $error("reserved address bits not zero");
  AST_REFUSE_READ: assert property (nv_busy &&
    $past(nv_busy, 2) |-> !cpu_stall)
    else $error("stall while programming");
  cover property ($rose(nv_busy));
  cover property ($fell(nv_busy));
  cover property (ctl_wr && io_wdata[0]);
endmodule
bind nvp_port nvp_port_chk #(.ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC))
  chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .cpu_stall(cpu_stall), .nv_busy(nv_busy));

// ### bench/nvp_cpu.sv
`timescale 1ns/1ns
// ==========================================================
// processor side of the I/O bus
module nvp_cpu
  import nvp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] io_rdata,
  output logic [nvp_pkg::NVP_IO_AW-1:0] io_addr = 6'h00,
  output logic io_wr = 1'b0,
  output logic io_rd = 1'b0,
  output logic [7:0] io_wdata = 8'h00
);
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge ref_clk);
    io_wr <= 1'b0;
    io_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    #1;
    d = io_rdata;
  endtask
  // address first, then the timed enable pair
  task automatic prog(input logic [8:0] a, input logic [7:0] d,
    input logic [1:0] m, input int gap);
    wr(NVP_IO_ADDR_LOW, a[7:0]);
    wr(NVP_IO_ADDR_HIGH, {7'h00, a[8]});
    wr(NVP_IO_DATA, d);
    wr(NVP_IO_CONTROL, {2'h0, m, 4'h4});
    repeat (gap) @(posedge ref_clk);
    wr(NVP_IO_CONTROL, {2'h0, m, 4'h2});
  endtask
  task automatic fetch(input logic [8:0] a, output logic [7:0] d);
    wr(NVP_IO_ADDR_LOW, a[7:0]);
    wr(NVP_IO_ADDR_HIGH, {7'h00, a[8]});
    wr(NVP_IO_CONTROL, 8'h01);
    rd(NVP_IO_DATA, d);
  endtask
endmodule

// ### bench/nvp_port_bench.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench for the access port
module nvp_port_bench;
  import nvp_pkg::*;
  localparam int CAP = 256;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] io_addr;
  logic io_wr, io_rd, cpu_stall, nv_busy;
  logic [7:0] io_wdata, io_rdata, d, g;
  logic [8:0] a;
  logic [31:0] rs = 32'h0000BA52;
  int mismatches = 0;
  int num_checks = 0;
  int mem [int];
  int i;
  always #4 ref_clk = ~ref_clk;
  nvp_port #(.CAPACITY(CAP), .ATOMIC_CYC(20), .SPLIT_CYC(10)) dut
    (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .cpu_stall(cpu_stall), .nv_busy(nv_busy));
  nvp_cpu cpu (.ref_clk(ref_clk), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task idle();
    int k;
    for (k = 0; k < 100; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (nv_busy === 1'b0)
        break;
    end
    if (k == 100)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  task model(input logic [8:0] ad, input logic [7:0] dv, input logic [1:0] m);
    case (m)
      2'h0: mem[ad % CAP] = dv;
      2'h1: mem[ad % CAP] = 8'hFF;
      2'h2: mem[ad % CAP] = mem[ad % CAP] & dv;
      default: ;
    endcase
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cpu.rd(NVP_IO_DATA, g);
    chk(g, NVP_DATA_RESET);
    cpu.wr(NVP_IO_ADDR_HIGH, 8'hFF);
    cpu.rd(NVP_IO_ADDR_HIGH, g);
    chk(g, 8'h01);
    d = 8'(xs());
    cpu.wr(NVP_IO_DATA, d);
    cpu.rd(NVP_IO_DATA, g);
    chk(g, d);
    $display("register test done");
    // modes erase, write, reserved, atomic on each address
    for (i = 0; i < 8; i++)
    begin
      if (i % 4 == 0)
        a = 9'(xs());
      d = 8'(xs());
      cpu.prog(a, d, 2'(i + 1), i % 3);
      model(a, d, 2'(i + 1));
      idle();
      cpu.fetch(a, g);
      chk(g, 8'(mem[a % CAP]));
    end
    cpu.fetch(a ^ 9'h100, g);
    chk(g, 8'(mem[a % CAP]));
    $display("mode test done");
    cpu.prog(a, 8'(xs()), 2'h0, 3);
    idle();
    cpu.fetch(a, g);
    chk(g, 8'(mem[a % CAP]));
    $display("late enable test done");
    d = 8'(xs());
    cpu.prog(a, d, 2'h0, 0);
    model(a, d, 2'h0);
    cpu.wr(NVP_IO_ADDR_LOW, ~a[7:0]);
    cpu.wr(NVP_IO_CONTROL, 8'h31);
    cpu.rd(NVP_IO_CONTROL, g);
    chk(g, 8'h02);
    idle();
    cpu.wr(NVP_IO_CONTROL, 8'h01);
    cpu.rd(NVP_IO_DATA, g);
    chk(g, 8'(mem[a % CAP]));
    $display("busy refusal test done");
    // programming time must not run while the clock enable is low
    d = 8'(xs());
    cpu.prog(a, d, 2'h2, 0);
    model(a, d, 2'h2);
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk({7'h00, nv_busy}, 8'h01);
    clk_en <= 1'b1;
    idle();
    cpu.fetch(a, g);
    chk(g, 8'(mem[a % CAP]));
    $display("clock enable freeze test done");
    cpu.wr(NVP_IO_CONTROL, 8'h28);
    cpu.rd(NVP_IO_CONTROL, g);
    chk(g, 8'h28);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cpu.rd(NVP_IO_CONTROL, g);
    chk(g, 8'h00);
    cpu.rd(NVP_IO_DATA, g);
    chk(g, NVP_DATA_RESET);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
